// ==== logic/cpu_regs.sv ====
// Purpose: Programmer-visible register set, effective address and page decode.
// Assumes: Avalon-MM slave on sys_clk_in; software drives instructions as commands.
// Notes:   Every request answers with waitrequest low on its second cycle.
// How it works
// - Accumulators A and B are 8 bits and read together as 16-bit D.
// - Indexed address is index register plus unsigned 8-bit offset.
// - Second-index instructions carry a prefix: one more byte and cycle.
// - Stack pointer names the next free slot; push decrements, pull increments.
// - The 16-bit program counter holds the next instruction address.
// - Carry follows ALU carry or borrow, and also shifts.
// - Overflow is set on arithmetic overflow, else cleared.
// - Zero is set when the latest result is zero, else cleared.
// - Negative copies the result's most significant bit.
// - A set interrupt mask blocks every maskable interrupt source.
// - Half carry reflects carry from bit 3 to bit 4 on adds.
// - Nonmaskable mask set by reset or acknowledge, cleared by flag transfers.
// - Stop executes as no-operation while the stop-disable flag is set.
// - Immediate operand follows the opcode, as wide as the destination.
// - Direct address uses the byte after the opcode, high byte zero.
// - Extended address is the two bytes after the opcode.
// - Inherent instructions touch registers only, no memory operand.
// - A taken branch adds the signed offset, otherwise execution continues.
// - No prefix means page one; prefix value selects pages two to four.
`timescale 1ns/1ps
module cpu_regs
	import cpu_regs_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [5:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [3:0]  avs_byteenable_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        irq_req_n_in,
	input  wire logic        nonmaskable_int_pin_n_in,
	input  wire logic        nmi_ack_in,
	output logic             irq_pass_out,
	output logic             nmi_pass_out,
	output logic             stop_enter_out
);
	logic [7:0]  acc_a_q;
	logic [7:0]  acc_b_q;
	logic [15:0] first_index_reg_q;
	logic [15:0] second_index_reg_q;
	logic [15:0] stack_top_pointer_q;
	logic [15:0] next_instr_pointer_q;
	logic [7:0]  flag_byte_q;
	logic [31:0] instr_q;
	logic        wait_q;
	logic [1:0]  irq_sync_q;
	logic [1:0]  nmi_sync_q;
	logic        rd_take;
	logic        wr_take;
	logic        cmd_go;
	logic [3:0]  cmd_op;
	logic [7:0]  cmd_opnd;
	logic        cmd_cond;
	logic [31:0] wmask;
	logic [1:0]  page_idx;
	logic        prefixed;
	logic [7:0]  opc;
	logic [7:0]  opnd1;
	logic [7:0]  opnd2;
	addr_mode_t  mode;
	logic        wide;
	logic        use_idx2;
	logic [2:0]  ilen;
	logic [15:0] ea;
	logic [15:0] pc_after;
	logic [31:0] decode_word;
	logic [31:0] rd_mux;
	logic        alu_op;
	logic [7:0]  alu_res;
	logic        alu_h;
	logic        alu_v;
	logic        alu_c;
	logic        alu_upd_h;
	logic        alu_upd_c;
	logic [7:0]  alu_b;

	// Addressing mode from the high nibble of the page opcode.
	function automatic addr_mode_t mode_of(input logic [7:0] op);
		case (op[7:4])
			4'h8, 4'hC: mode_of = MODE_IMM;
			4'h9, 4'hD: mode_of = MODE_DIR;
			4'hB, 4'hF: mode_of = MODE_EXT;
			4'hA, 4'hE: mode_of = MODE_IDX;
			4'h2:       mode_of = MODE_REL;
			default:    mode_of = MODE_INH;
		endcase
	endfunction

	// Sixteen-bit destinations take two immediate bytes.
	function automatic logic wide_of(input logic [7:0] op);
		wide_of = (op[3:0] == 4'h3) || (op[3:0] == 4'hC) || (op[3:0] == 4'hE);
	endfunction

	// Byte-enable merge used by every writable register.
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Bus handshake: a request is answered on its second cycle.
	assign rd_take  = avs_read_in && !wait_q;
	assign wr_take  = avs_write_in && !wait_q;
	assign wmask    = be_mask(avs_byteenable_in);
	assign cmd_go   = wr_take && (avs_address_in == OFS_CMD);
	assign cmd_op   = avs_writedata_in[3:0];
	assign cmd_cond = avs_writedata_in[CMD_COND];
	assign cmd_opnd = avs_writedata_in[CMD_OPND +: 8];

	// Page select from the prefix byte; page one needs none.
	always_comb begin
		case (instr_q[7:0])
			PRE_PAGE2: page_idx = 2'h1;
			PRE_PAGE3: page_idx = 2'h2;
			PRE_PAGE4: page_idx = 2'h3;
			default:   page_idx = 2'h0;
		endcase
	end

	// Opcode and operand bytes shift by one when a prefix is present.
	assign prefixed = (page_idx != 2'h0);
	assign opc      = prefixed ? instr_q[15:8] : instr_q[7:0];
	assign opnd1    = prefixed ? instr_q[23:16] : instr_q[15:8];
	assign opnd2    = prefixed ? instr_q[31:24] : instr_q[23:16];
	assign mode     = mode_of(opc);
	assign wide     = wide_of(opc);
	assign use_idx2 = (page_idx == 2'h1) && (mode == MODE_IDX);

	// Instruction length; the prefix costs one byte and one cycle.
	always_comb begin
		ilen = prefixed ? 3'h2 : 3'h1;
		case (mode)
			MODE_IMM: ilen = ilen + (wide ? 3'h2 : 3'h1);
			MODE_DIR: ilen = ilen + 3'h1;
			MODE_EXT: ilen = ilen + 3'h2;
			MODE_IDX: ilen = ilen + 3'h1;
			MODE_REL: ilen = ilen + 3'h1;
			default:  ilen = ilen + 3'h0;
		endcase
	end

	assign pc_after = next_instr_pointer_q + {13'h0000, ilen};

	// Effective address per mode; inherent has no memory operand.
	always_comb begin
		case (mode)
			MODE_IMM: ea = next_instr_pointer_q + (prefixed ? 16'h0002 : 16'h0001);
			MODE_DIR: ea = {8'h00, opnd1};
			MODE_EXT: ea = {opnd1, opnd2};
			MODE_IDX: ea = (use_idx2 ? second_index_reg_q : first_index_reg_q) + {8'h00, opnd1};
			MODE_REL: ea = pc_after + {{8{opnd1[7]}}, opnd1};
			default:  ea = WORD_RST;
		endcase
	end

	// Decode status word seen by software.
	always_comb begin
		decode_word                      = 32'h0000_0000;
		decode_word[DEC_PAGE +: 2]       = page_idx;
		decode_word[DEC_MODE +: 3]       = mode;
		decode_word[DEC_IDX2]            = use_idx2;
		decode_word[DEC_WIDE]            = wide;
		decode_word[DEC_EXTRA]           = prefixed;
		decode_word[DEC_LEN +: 3]        = ilen;
		decode_word[DEC_OPC +: 8]        = opc;
	end

	// Second operand: accumulator B for the accumulator add, else the command byte.
	assign alu_op = cmd_go && (cmd_op >= OP_ADD) && (cmd_op <= OP_LDA);
	assign alu_b  = (cmd_op == OP_ADDACC) ? acc_b_q : cmd_opnd;

	flag_alu u_alu (
		.op_in     (cmd_op),
		.a_in      (acc_a_q),
		.b_in      (alu_b),
		.cin_in    ((cmd_op == OP_ADC) && flag_byte_q[FLG_C]),
		.res_out   (alu_res),
		.h_out     (alu_h),
		.v_out     (alu_v),
		.c_out     (alu_c),
		.upd_h_out (alu_upd_h),
		.upd_c_out (alu_upd_c)
	);

	// Bus wait state: high while idle, low for exactly one cycle per request.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			wait_q <= 1'b1;
		end else if ((avs_read_in || avs_write_in) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	assign avs_waitrequest_out = wait_q;

	// Read mux; unmapped offsets read zero.
	always_comb begin
		case (avs_address_in)
			OFS_ACC:    rd_mux = {16'h0000, acc_a_q, acc_b_q};
			OFS_IDX1:   rd_mux = {16'h0000, first_index_reg_q};
			OFS_IDX2:   rd_mux = {16'h0000, second_index_reg_q};
			OFS_STACK:  rd_mux = {16'h0000, stack_top_pointer_q};
			OFS_NEXT:   rd_mux = {16'h0000, next_instr_pointer_q};
			OFS_FLAGS:  rd_mux = {24'h000000, flag_byte_q};
			OFS_INSTR:  rd_mux = instr_q;
			OFS_DECODE: rd_mux = decode_word;
			OFS_EA:     rd_mux = {16'h0000, ea};
			OFS_STATUS: rd_mux = {29'h00000000, stop_enter_out, nmi_pass_out, irq_pass_out};
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured as waitrequest drops, so it stands at the taking edge.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && wait_q) begin
			avs_readdata_out <= rd_mux;
		end
	end

	// Accumulators: bus writes and ALU results; D is A in the high byte.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			acc_a_q <= 8'h00;
			acc_b_q <= 8'h00;
		end else if (wr_take && (avs_address_in == OFS_ACC)) begin
			{acc_a_q, acc_b_q} <= ({acc_a_q, acc_b_q} & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
		end else if (alu_op) begin
			acc_a_q <= alu_res;
		end
	end

	// Index registers, written from the bus only.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			first_index_reg_q  <= WORD_RST;
			second_index_reg_q <= WORD_RST;
		end else if (wr_take && (avs_address_in == OFS_IDX1)) begin
			first_index_reg_q <= (first_index_reg_q & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
		end else if (wr_take && (avs_address_in == OFS_IDX2)) begin
			second_index_reg_q <= (second_index_reg_q & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
		end
	end

	// Stack pointer moves one byte per push or pull.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			stack_top_pointer_q <= WORD_RST;
		end else if (wr_take && (avs_address_in == OFS_STACK)) begin
			stack_top_pointer_q <= (stack_top_pointer_q & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
		end else if (cmd_go && (cmd_op == OP_PUSH)) begin
			stack_top_pointer_q <= stack_top_pointer_q - 16'h0001;
		end else if (cmd_go && (cmd_op == OP_PULL)) begin
			stack_top_pointer_q <= stack_top_pointer_q + 16'h0001;
		end
	end

	// Program counter: step past the instruction, or take a branch.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			next_instr_pointer_q <= WORD_RST;
		end else if (wr_take && (avs_address_in == OFS_NEXT)) begin
			next_instr_pointer_q <= (next_instr_pointer_q & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
		end else if (cmd_go && (cmd_op == OP_STEP)) begin
			next_instr_pointer_q <= pc_after;
		end else if (cmd_go && (cmd_op == OP_BRANCH)) begin
			next_instr_pointer_q <= (cmd_cond && (mode == MODE_REL)) ? ea : pc_after;
		end
	end

	// Instruction window bytes, lowest byte at the program counter.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			instr_q <= 32'h0000_0000;
		end else if (wr_take && (avs_address_in == OFS_INSTR)) begin
			instr_q <= (instr_q & ~wmask) | (avs_writedata_in & wmask);
		end
	end

	// Flag byte. The nonmaskable mask may only be cleared by transfers, and an
	// acknowledge in the same cycle as such a transfer wins so the edge is not lost.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			flag_byte_q <= FLAGS_RST;
		end else begin
			if (alu_op) begin
				flag_byte_q[FLG_Z] <= (alu_res == 8'h00);
				flag_byte_q[FLG_N] <= alu_res[7];
				flag_byte_q[FLG_V] <= alu_v;
				if (alu_upd_c) begin
					flag_byte_q[FLG_C] <= alu_c;
				end
				if (alu_upd_h) begin
					flag_byte_q[FLG_H] <= alu_h;
				end
			end else if (cmd_go && ((cmd_op == OP_TAP) || (cmd_op == OP_RETINT))) begin
				flag_byte_q <= (cmd_op == OP_TAP) ? acc_a_q : cmd_opnd;
				flag_byte_q[FLG_X] <= flag_byte_q[FLG_X] & ((cmd_op == OP_TAP) ? acc_a_q[FLG_X] : cmd_opnd[FLG_X]);
			end
			if (nmi_ack_in) begin
				flag_byte_q[FLG_X] <= 1'b1;
				flag_byte_q[FLG_I] <= 1'b1;
			end
		end
	end

	// Pin synchronisers; only the second stage is read.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			irq_sync_q <= 2'b11;
			nmi_sync_q <= 2'b11;
		end else begin
			irq_sync_q <= {irq_sync_q[0], irq_req_n_in};
			nmi_sync_q <= {nmi_sync_q[0], nonmaskable_int_pin_n_in};
		end
	end

	// Interrupt gating by the two mask flags.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			irq_pass_out <= 1'b0;
			nmi_pass_out <= 1'b0;
		end else begin
			irq_pass_out <= !irq_sync_q[1] && !flag_byte_q[FLG_I];
			nmi_pass_out <= !nmi_sync_q[1] && !flag_byte_q[FLG_X];
		end
	end

	// Stop request pulses for one cycle only when stop is enabled.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			stop_enter_out <= 1'b0;
		end else begin
			stop_enter_out <= cmd_go && (cmd_op == OP_STOP) && !flag_byte_q[FLG_S];
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_cmd(logic [3:0] op);
		cmd_go && (cmd_op == op);
	endsequence

	sequence s_acc_write;
		wr_take && (avs_address_in == OFS_ACC) && (avs_byteenable_in == 4'hF);
	endsequence

	AST_ACC_CONCAT: assert property (s_acc_write |=> ({acc_a_q, acc_b_q} == $past(avs_writedata_in[15:0])))
		else $error("accumulator pair did not take written word");
	AST_IDX_EA: assert property ((mode == MODE_IDX) |-> (ea == ((use_idx2 ? second_index_reg_q : first_index_reg_q) + {8'h00, opnd1})))
		else $error("indexed address wrong");
	AST_IDX2_LEN: assert property (use_idx2 |-> (ilen == 3'h3) && decode_word[DEC_EXTRA])
		else $error("second index instruction length wrong");
	AST_PUSH: assert property (s_cmd(OP_PUSH) |=> (stack_top_pointer_q == $past(stack_top_pointer_q) - 16'h0001))
		else $error("push did not decrement stack");
	AST_PULL: assert property (s_cmd(OP_PULL) |=> (stack_top_pointer_q == $past(stack_top_pointer_q) + 16'h0001))
		else $error("pull did not increment stack");
	AST_STEP: assert property (s_cmd(OP_STEP) |=> (next_instr_pointer_q == $past(pc_after)))
		else $error("step did not advance program counter");
	AST_CARRY: assert property (alu_op && alu_upd_c && !nmi_ack_in |=> (flag_byte_q[FLG_C] == $past(alu_c)))
		else $error("carry flag not updated");
	AST_ZERO_NEG: assert property (alu_op |=> (flag_byte_q[FLG_Z] == (acc_a_q == 8'h00)) && (flag_byte_q[FLG_N] == acc_a_q[7]))
		else $error("zero or negative flag wrong");
	AST_IRQ_MASK: assert property (flag_byte_q[FLG_I] |=> !irq_pass_out)
		else $error("maskable interrupt passed while masked");
	AST_XMASK_SET: assert property (nmi_ack_in |=> flag_byte_q[FLG_X] ##1 (flag_byte_q[FLG_X] || $past(cmd_go)))
		else $error("nonmaskable mask not set on acknowledge");
	AST_STOP_NOP: assert property (s_cmd(OP_STOP) ##0 flag_byte_q[FLG_S] |=> !stop_enter_out)
		else $error("stop ran while disabled");
	AST_DIRECT: assert property ((mode == MODE_DIR) |-> (ea[15:8] == 8'h00))
		else $error("direct address high byte not zero");
	AST_BRANCH: assert property (s_cmd(OP_BRANCH) ##0 (cmd_cond && (mode == MODE_REL))
		|=> (next_instr_pointer_q == $past(pc_after) + {{8{$past(opnd1[7])}}, $past(opnd1)}))
		else $error("branch target wrong");
endmodule

// ==== logic/cpu_regs_pkg.sv ====
// Purpose: Shared constants for the CPU register set and address decoder.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Command codes and field positions are software visible.
package cpu_regs_pkg;
	// Register byte offsets.
	localparam logic [5:0] OFS_ACC    = 6'h00;
	localparam logic [5:0] OFS_IDX1   = 6'h04;
	localparam logic [5:0] OFS_IDX2   = 6'h08;
	localparam logic [5:0] OFS_STACK  = 6'h0C;
	localparam logic [5:0] OFS_NEXT   = 6'h10;
	localparam logic [5:0] OFS_FLAGS  = 6'h14;
	localparam logic [5:0] OFS_INSTR  = 6'h18;
	localparam logic [5:0] OFS_DECODE = 6'h1C;
	localparam logic [5:0] OFS_EA     = 6'h20;
	localparam logic [5:0] OFS_CMD    = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	// Flag byte bit positions.
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam int FLG_I = 4;
	localparam int FLG_H = 5;
	localparam int FLG_X = 6;
	localparam int FLG_S = 7;
	localparam logic [7:0] FLAGS_RST = 8'hD0;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// Prefix bytes selecting opcode pages two, three and four.
	localparam logic [7:0] PRE_PAGE2 = 8'h18;
	localparam logic [7:0] PRE_PAGE3 = 8'h1A;
	localparam logic [7:0] PRE_PAGE4 = 8'hCD;
	// Decode word field positions.
	localparam int DEC_PAGE  = 0;
	localparam int DEC_MODE  = 2;
	localparam int DEC_IDX2  = 5;
	localparam int DEC_WIDE  = 6;
	localparam int DEC_EXTRA = 7;
	localparam int DEC_LEN   = 8;
	localparam int DEC_OPC   = 16;
	// Command word fields and codes.
	localparam int CMD_COND = 4;
	localparam int CMD_OPND = 8;
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_ADD    = 4'h1;
	localparam logic [3:0] OP_ADC    = 4'h2;
	localparam logic [3:0] OP_ADDACC = 4'h3;
	localparam logic [3:0] OP_SUB    = 4'h4;
	localparam logic [3:0] OP_AND    = 4'h5;
	localparam logic [3:0] OP_ASL    = 4'h6;
	localparam logic [3:0] OP_LSR    = 4'h7;
	localparam logic [3:0] OP_LDA    = 4'h8;
	localparam logic [3:0] OP_PUSH   = 4'h9;
	localparam logic [3:0] OP_PULL   = 4'hA;
	localparam logic [3:0] OP_STEP   = 4'hB;
	localparam logic [3:0] OP_BRANCH = 4'hC;
	localparam logic [3:0] OP_TAP    = 4'hD;
	localparam logic [3:0] OP_STOP   = 4'hE;
	localparam logic [3:0] OP_RETINT = 4'hF;
	// Addressing modes.
	typedef enum logic [2:0] {
		MODE_INH,
		MODE_IMM,
		MODE_DIR,
		MODE_EXT,
		MODE_IDX,
		MODE_REL
	} addr_mode_t;
endpackage

// ==== logic/flag_alu.sv ====
// Purpose: 8-bit arithmetic and logic unit with flag results.
// Assumes: Pure combinational; the caller latches result and flags.
// Notes:   upd_h and upd_c tell which flags the operation touches.
`timescale 1ns/1ps
module flag_alu
	import cpu_regs_pkg::*;
(
	input  wire logic [3:0] op_in,
	input  wire logic [7:0] a_in,
	input  wire logic [7:0] b_in,
	input  wire logic       cin_in,
	output logic      [7:0] res_out,
	output logic            h_out,
	output logic            v_out,
	output logic            c_out,
	output logic            upd_h_out,
	output logic            upd_c_out
);
	logic [8:0] sum;
	logic [4:0] low;

	// Operation select; carry into bit 4 is watched for adds only.
	always_comb begin
		sum       = 9'h000;
		low       = 5'h00;
		res_out   = a_in;
		h_out     = 1'b0;
		v_out     = 1'b0;
		c_out     = 1'b0;
		upd_h_out = 1'b0;
		upd_c_out = 1'b0;
		case (op_in)
			OP_ADD, OP_ADC, OP_ADDACC: begin
				sum       = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
				low       = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
				res_out   = sum[7:0];
				h_out     = low[4];
				c_out     = sum[8];
				v_out     = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]);
				upd_h_out = 1'b1;
				upd_c_out = 1'b1;
			end
			OP_SUB: begin
				sum       = {1'b0, a_in} - {1'b0, b_in};
				res_out   = sum[7:0];
				c_out     = sum[8];
				v_out     = (a_in[7] != b_in[7]) && (sum[7] != a_in[7]);
				upd_c_out = 1'b1;
			end
			OP_AND: res_out = a_in & b_in;
			OP_LDA: res_out = b_in;
			OP_ASL: begin
				res_out   = {a_in[6:0], 1'b0};
				c_out     = a_in[7];
				v_out     = a_in[7] ^ a_in[6];
				upd_c_out = 1'b1;
			end
			OP_LSR: begin
				res_out   = {1'b0, a_in[7:1]};
				c_out     = a_in[0];
				v_out     = a_in[0];
				upd_c_out = 1'b1;
			end
			default: res_out = a_in;
		endcase
	end
endmodule

// ==== sim/prog_mem_model.sv ====
// Purpose: Program memory seen by the core, the source of instruction bytes.
// Assumes: 256 bytes suffice; higher address bits are ignored.
// Notes:   Four bytes from the addressed one on are fetched little end first.
`timescale 1ns/1ps
module prog_mem_model (
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [31:0] fetch_out
);
	logic [7:0] mem_q [256];
	// Byte store; the bench loads a program one byte per cycle.
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_q[addr_in] <= wdata_in;
		end
	end
	// The fetch wraps at the top, which keeps the model small.
	assign fetch_out = {mem_q[addr_in + 8'h03], mem_q[addr_in + 8'h02], mem_q[addr_in + 8'h01], mem_q[addr_in]};
endmodule

// ==== sim/test_cpu_regs.sv ====
// Purpose: Self-checking bench for the register set and address decoder.
// Assumes: One wait state per bus request; reads are checked by a monitor.
// Notes:   Expected read values are queued by the driver in request order.
`timescale 1ns/1ps
module test_cpu_regs import cpu_regs_pkg::*; ;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [5:0]  a_q = 6'h00;
	logic        rd_q = 1'b0;
	logic        wr_q = 1'b0;
	logic [31:0] wd_q = 32'h0;
	logic [31:0] rdata;
	logic        wait_r;
	logic        irq_n = 1'b1;
	logic        nmi_n = 1'b1;
	logic        ack = 1'b0;
	logic        irq_p;
	logic        nmi_p;
	logic        stop_p;
	logic        m_we = 1'b0;
	logic [7:0]  m_a = 8'h00;
	logic [7:0]  m_d = 8'h00;
	logic [31:0] m_f;
	logic [31:0] expq [$];
	logic [31:0] rnd = 32'h0D4D89D0;
	int          num_errors = 0;
	int          n_checks = 0;
	int          stops = 0;
	// Clock at 25 MHz.
	always #20 sys_clk_in = ~sys_clk_in;
	cpu_regs i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .avs_address_in(a_q), .avs_read_in(rd_q),
		.avs_write_in(wr_q), .avs_byteenable_in(4'hF), .avs_writedata_in(wd_q), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_r), .irq_req_n_in(irq_n), .nonmaskable_int_pin_n_in(nmi_n),
		.nmi_ack_in(ack), .irq_pass_out(irq_p), .nmi_pass_out(nmi_p), .stop_enter_out(stop_p));
	prog_mem_model i_mem (.clk_in(sys_clk_in), .we_in(m_we), .addr_in(m_a), .wdata_in(m_d), .fetch_out(m_f));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One request held until waitrequest is seen low, then one idle edge.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] e);
		int n;
		if (!w) expq.push_back(e);
		a_q <= a;
		wd_q <= d;
		wr_q <= w;
		rd_q <= !w;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			summarize();
		end
		wr_q <= 1'b0;
		rd_q <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic cmd(input logic [3:0] op, input logic c, input logic [7:0] o);
		bus(1'b1, OFS_CMD, {16'h0, o, 3'h0, c, op}, 32'h0);
	endtask
	// Loads four program bytes at an address, points the counter there and fetches them.
	task automatic mode(input logic [7:0] at, input logic [31:0] w, input logic [31:0] dec, input logic [31:0] ea);
		for (int i = 0; i < 4; i++) begin
			m_we <= 1'b1;
			m_a <= at + 8'(i);
			m_d <= w[8*i +: 8];
			@(posedge sys_clk_in);
		end
		m_we <= 1'b0;
		m_a <= at;
		@(posedge sys_clk_in);
		bus(1'b1, OFS_NEXT, {24'h0, at}, 32'h0);
		bus(1'b1, OFS_INSTR, m_f, 32'h0);
		bus(1'b0, OFS_DECODE, 32'h0, dec);
		bus(1'b0, OFS_EA, 32'h0, ea);
	endtask
	// Read monitor: each completed read is matched against the oldest note.
	always @(posedge sys_clk_in) begin
		if (rd_q && wait_r === 1'b0) chk(rdata, expq.pop_front());
		if (stop_p === 1'b1) stops++;
	end
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(posedge sys_clk_in);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hD0);
		bus(1'b0, 6'h3C, 32'h0, 32'h0);
		bus(1'b1, OFS_FLAGS, 32'hFF, 32'h0);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hD0);
		bus(1'b1, OFS_ACC, 32'h7F01, 32'h0);
		cmd(OP_ADDACC, 1'b0, 8'h00);
		bus(1'b0, OFS_ACC, 32'h0, 32'h8001);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hFA);
		cmd(OP_ADD, 1'b0, 8'h80);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hD7);
		cmd(OP_LDA, 1'b0, 8'h81);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hD9);
		cmd(OP_ASL, 1'b0, 8'h00);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hD3);
		cmd(OP_ADC, 1'b0, 8'h0F);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hF0);
		cmd(OP_SUB, 1'b0, 8'h13);
		bus(1'b0, OFS_ACC, 32'h0, 32'hFF01);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hF9);
		cmd(OP_LSR, 1'b0, 8'h00);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hF3);
		cmd(OP_AND, 1'b0, 8'h80);
		cmd(OP_NOP, 1'b0, 8'h00);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'hF5);
		$display("test arithmetic done");
		rnd = lfsr(rnd);
		bus(1'b1, OFS_IDX1, {16'h0, rnd[15:0]}, 32'h0);
		bus(1'b1, OFS_IDX2, 32'h1000, 32'h0);
		mode(8'h10, 32'h4296, 32'h960208, 32'h42);
		mode(8'h10, 32'h3412B6, 32'hB6030C, 32'h1234);
		mode(8'h10, 32'h558B, 32'h8B0204, 32'h11);
		mode(8'h10, 32'h7766C3, 32'hC30344, 32'h11);
		mode(8'h10, 32'h01, 32'h010100, 32'h0);
		mode(8'h10, 32'h0118, 32'h010281, 32'h0);
		mode(8'h10, 32'h011A, 32'h010282, 32'h0);
		mode(8'h10, 32'h01CD, 32'h010283, 32'h0);
		mode(8'h20, {16'h0, rnd[23:16], 8'hA6}, 32'hA60210, {16'h0, rnd[15:0] + {8'h0, rnd[23:16]}});
		mode(8'h20, 32'h05A618, 32'hA603B1, 32'h1005);
		mode(8'h80, 32'hFE20, 32'h200214, 32'h80);
		cmd(OP_BRANCH, 1'b1, 8'h00);
		bus(1'b0, OFS_NEXT, 32'h0, 32'h80);
		cmd(OP_BRANCH, 1'b0, 8'h00);
		bus(1'b0, OFS_NEXT, 32'h0, 32'h82);
		cmd(OP_STEP, 1'b0, 8'h00);
		bus(1'b0, OFS_NEXT, 32'h0, 32'h84);
		$display("test addressing done");
		bus(1'b1, OFS_STACK, 32'h0100, 32'h0);
		cmd(OP_PUSH, 1'b0, 8'h00);
		bus(1'b0, OFS_STACK, 32'h0, 32'h00FF);
		cmd(OP_PULL, 1'b0, 8'h00);
		cmd(OP_PULL, 1'b0, 8'h00);
		bus(1'b0, OFS_STACK, 32'h0, 32'h0101);
		cmd(OP_STOP, 1'b0, 8'h00);
		bus(1'b1, OFS_ACC, 32'h0, 32'h0);
		cmd(OP_TAP, 1'b0, 8'h00);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'h0);
		chk(stops, 0);
		cmd(OP_STOP, 1'b0, 8'h00);
		repeat (2) @(posedge sys_clk_in);
		chk(stops, 1);
		$display("test stack and stop done");
		irq_n <= 1'b0;
		nmi_n <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		chk({nmi_p, irq_p}, 2'b11);
		cmd(OP_RETINT, 1'b0, 8'h10);
		repeat (5) @(posedge sys_clk_in);
		chk({nmi_p, irq_p}, 2'b10);
		ack <= 1'b1;
		@(posedge sys_clk_in);
		ack <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		chk({nmi_p, irq_p}, 2'b00);
		bus(1'b0, OFS_FLAGS, 32'h0, 32'h50);
		$display("test interrupt masks done");
		summarize();
	end
endmodule
